// File: src/ready_synchronizer.sv
// design: processor ready synchronizer with selectable depth
`timescale 1ns/1ps
// What this block does
// R1 - a rising combined ready always passes flop two, and in two-stage mode flop one first, before processor ready rises.
// R2 - sources in normally-ready systems may drop ready unsynchronized but must meet setup and hold.
// R3 - two-stage mode: rise caught by flop one on rising edge, then flop two on falling edge, then ready high.
// R4 - two-stage mode: a fall skips flop one and is caught by flop two on a falling edge.
// R5 - single-stage mode: flop one is bypassed for both edges, flop two samples on the falling edge.
// R6 - the depth select may change each bus cycle and takes effect for that cycle.
// R7 - designers pick two-stage for unsynchronized sources, single-stage for synchronous ones.
// R8 - an unconnected depth select reads high, meaning single stage.
// R9 - each bus ready counts only while its own low qualifier is asserted.
// R10 - processor ready is active high and is the synchronized qualified ready.
// R11 - combined ready is the OR of each ready ANDed with its asserted qualifier.
module ready_synchronizer (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// ready sources
	input wire ready_sync_pkg::ready_src_s srcA,
	input wire ready_sync_pkg::ready_src_s srcB,
	// depth select, low for two stages
	input wire logic syncDepthSelect_n,
	input wire logic syncDepthSelectDriven,
	// processor side
	output logic processorReady
);

	// ==========================================
	// qualification
	logic depthSel;
	// per-lane qualified ready, kept apart so each lane can be watched
	logic qualifiedA;
	logic qualifiedB;
	logic combinedReady;
	// flop one only feeds two-stage mode but always runs, so a mode switch finds it current
	logic stageOne_reg;
	logic stageTwo_reg;
	logic stageTwo_next;

	// one lane passes ready only while its qualifier is low
	function automatic logic qualifiedReady(input ready_sync_pkg::ready_src_s src);
		return src.busReady & ~src.qualifierN;
	endfunction

	// R8 pull-up default
	// the open pin is modelled by a separate driven flag
	assign depthSel = syncDepthSelectDriven ? syncDepthSelect_n : ready_sync_pkg::SELECT_DEFAULT;

	// R9 per-lane qualifier
	assign qualifiedA = qualifiedReady(srcA);
	assign qualifiedB = qualifiedReady(srcB);

	// R11 qualified or
	assign combinedReady = qualifiedA | qualifiedB;

	// ==========================================
	// synchronizing flops
	// R3 rising edge capture
	// no input flops ahead of this one: this flop is the synchronizer itself
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stageOne_reg <= ready_sync_pkg::STAGE_ONE_RESET;
		end else begin
			stageOne_reg <= combinedReady;
		end
	end

	// R4 R5 R6 select per cycle; falls bypass stage one in both modes
	// select is read live at each falling edge, so a switch applies to that bus cycle
	always_comb begin
		if (depthSel) begin
			stageTwo_next = combinedReady;
		end else begin
			stageTwo_next = stageOne_reg & combinedReady;
		end
	end

	// R1 R3 falling edge stage
	// launching on the falling edge leaves the processor the low phase as setup
	always_ff @(negedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stageTwo_reg <= ready_sync_pkg::STAGE_TWO_RESET;
		end else begin
			stageTwo_reg <= stageTwo_next;
		end
	end

	// R10 output straight from flop two
	assign processorReady = stageTwo_reg;

	// ==========================================
	// assertions
	// flop two moves on the falling edge, so most properties sample there
	// lanes are taken as settled between edges, as the setup rule demands

	// R1 rise needs flop one
	property p_rise_needs_flop_one;
		@(negedge clk) disable iff (!reset_n)
			($rose(stageTwo_reg) && !$past(depthSel)) |-> $past(stageOne_reg);
	endproperty
	a_rise_needs_flop_one: assert property (p_rise_needs_flop_one) // R1 R3
		else $error("two-stage rise without flop one");

	// R3 flop one tracks
	property p_flop_one_follows;
		@(posedge clk) disable iff (!reset_n)
			1'h1 |=> (stageOne_reg == $past(combinedReady));
	endproperty
	a_flop_one_follows: assert property (p_flop_one_follows) // R3
		else $error("flop one missed the rising edge");

	// R3 two-stage rise
	property p_two_stage_rise;
		@(negedge clk) disable iff (!reset_n)
			(!depthSel && stageOne_reg && combinedReady) |=> processorReady;
	endproperty
	a_two_stage_rise: assert property (p_two_stage_rise) // R3
		else $error("two-stage rise too slow");

	// R4 fall goes direct
	property p_fall_direct;
		@(negedge clk) disable iff (!reset_n)
			!combinedReady |=> !processorReady;
	endproperty
	a_fall_direct: assert property (p_fall_direct) // R4
		else $error("ready did not drop after input fell");

	// R4 fall skips flop one
	property p_fall_ignores_flop_one;
		@(negedge clk) disable iff (!reset_n)
			(!depthSel && stageOne_reg && !combinedReady) |=> !processorReady;
	endproperty
	a_fall_ignores_flop_one: assert property (p_fall_ignores_flop_one) // R4
		else $error("two-stage fall held back by flop one");

	// R5 single stage
	property p_single_stage;
		@(negedge clk) disable iff (!reset_n)
			(depthSel && combinedReady) |=> processorReady;
	endproperty
	a_single_stage: assert property (p_single_stage) // R5
		else $error("single-stage rise missed");

	// R6 switch to single
	property p_mode_same_cycle;
		@(negedge clk) disable iff (!reset_n)
			($changed(depthSel) && depthSel && combinedReady) |=> processorReady;
	endproperty
	a_mode_same_cycle: assert property (p_mode_same_cycle) // R6
		else $error("new mode not applied");

	// R6 switch to two
	property p_mode_to_two_stage;
		@(negedge clk) disable iff (!reset_n)
			($changed(depthSel) && !depthSel && !stageOne_reg) |=> !processorReady;
	endproperty
	a_mode_to_two_stage: assert property (p_mode_to_two_stage) // R6
		else $error("two-stage mode not applied at once");

	// R8 open pin
	property p_default_select;
		@(posedge clk) disable iff (!reset_n)
			!syncDepthSelectDriven |-> depthSel;
	endproperty
	a_default_select: assert property (p_default_select) // R8
		else $error("open select not single stage");

	// R9 R11 both unqualified
	property p_unqualified;
		@(negedge clk) disable iff (!reset_n)
			(srcA.qualifierN && srcB.qualifierN) |=> !processorReady;
	endproperty
	a_unqualified: assert property (p_unqualified) // R9 R11
		else $error("ready passed without qualifier");

	// R9 lane A alone
	property p_lane_a_alone;
		@(negedge clk) disable iff (!reset_n)
			(depthSel && srcA.busReady && !srcA.qualifierN) |=> processorReady;
	endproperty
	a_lane_a_alone: assert property (p_lane_a_alone) // R9 R11
		else $error("qualified lane A ignored");

	// R9 lane B alone
	property p_lane_b_alone;
		@(negedge clk) disable iff (!reset_n)
			(depthSel && srcB.busReady && !srcB.qualifierN) |=> processorReady;
	endproperty
	a_lane_b_alone: assert property (p_lane_b_alone) // R9 R11
		else $error("qualified lane B ignored");

	// R9 lane A blocked
	property p_lane_a_blocked;
		@(negedge clk) disable iff (!reset_n)
			(srcA.qualifierN && !(srcB.busReady && !srcB.qualifierN)) |=> !processorReady;
	endproperty
	a_lane_a_blocked: assert property (p_lane_a_blocked) // R9
		else $error("unqualified lane A passed");

	// R9 lane B blocked
	property p_lane_b_blocked;
		@(negedge clk) disable iff (!reset_n)
			(srcB.qualifierN && !(srcA.busReady && !srcA.qualifierN)) |=> !processorReady;
	endproperty
	a_lane_b_blocked: assert property (p_lane_b_blocked) // R9
		else $error("unqualified lane B passed");

	// R10 ready origin
	property p_ready_from_input;
		@(negedge clk) disable iff (!reset_n)
			$rose(processorReady) |-> $past(combinedReady);
	endproperty
	a_ready_from_input: assert property (p_ready_from_input) // R10
		else $error("ready rose without input");

	// ==========================================
	// coverage
	// one cover per main scenario
	c_two_stage: cover property (@(negedge clk) disable iff (!reset_n) !depthSel ##1 $rose(processorReady));
	c_single_stage: cover property (@(negedge clk) disable iff (!reset_n) depthSel ##1 $rose(processorReady));
	c_fall: cover property (@(negedge clk) disable iff (!reset_n) $fell(processorReady));
	c_mode_change: cover property (@(negedge clk) disable iff (!reset_n) $changed(depthSel) ##1 processorReady);
	c_fall_two_stage: cover property (@(negedge clk) disable iff (!reset_n) !depthSel && $fell(processorReady));
endmodule

// File: common/ready_sync_pkg.sv
// package: shared types and reset values for the ready synchronizer
package ready_sync_pkg;
	// one qualified ready source
	typedef struct packed {
		logic busReady;
		logic qualifierN;
	} ready_src_s;

	localparam logic STAGE_ONE_RESET = 1'h0;
	localparam logic STAGE_TWO_RESET = 1'h0;
	// pulled-up select defaults to single stage
	localparam logic SELECT_DEFAULT = 1'h1;
endpackage

// File: dv/ready_source_model.sv
// partner: two qualified ready sources
`timescale 1ns/1ps
module ready_source_model (
	// clock
	input wire logic clk,
	// commands, index 0 is source A
	input wire logic [1:0] want,
	input wire logic [1:0] grant,
	// to the block
	output ready_sync_pkg::ready_src_s srcA,
	output ready_sync_pkg::ready_src_s srcB
);
	logic junk = 1'h0;
	always_ff @(posedge clk) junk <= ~junk;
	// unqualified lines churn, changes follow rising edge
	assign srcA = {grant[0] ? want[0] : junk, ~grant[0]};
	assign srcB = {grant[1] ? want[1] : ~junk, ~grant[1]};
endmodule

// File: dv/ready_synchronizer_tb.sv
// bench: ready synchronizer scenarios
`timescale 1ns/1ps
module ready_synchronizer_tb;
	logic clk = 1'h0, reset_n = 1'h0, selN = 1'h1, selDrv = 1'h1, processorReady;
	logic [1:0] want = 2'h0, grant = 2'h0;
	ready_sync_pkg::ready_src_s srcA, srcB;
	int miscompares = 0, n_checks = 0;
	ready_source_model ready_source_model_i (.clk(clk), .want(want), .grant(grant), .srcA(srcA), .srcB(srcB));
	ready_synchronizer ready_synchronizer_i (.clk(clk), .reset_n(reset_n), .srcA(srcA), .srcB(srcB),
		.syncDepthSelect_n(selN), .syncDepthSelectDriven(selDrv), .processorReady(processorReady));
	initial forever #12.5 clk = ~clk;
	task check(input logic seen, input logic exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t processor ready wrong", $time);
		end
	endtask
	// entered just after a rising edge; late means two stages
	task run(input int lane, input logic s, input logic d, input logic late);
		selN = s; selDrv = d; want[lane] = 1'h1; grant[lane] = 1'h1;
		@(negedge clk); #1 check(processorReady, ~late);
		@(negedge clk); #1 check(processorReady, 1'h1);
		@(posedge clk); #2 want[lane] = 1'h0;
		@(negedge clk); #1 check(processorReady, 1'h0);
		@(posedge clk); #2;
	endtask
	task single_stage_a; run(0, 1'h1, 1'h1, 1'h0); endtask
	task two_stage_b; run(1, 1'h0, 1'h1, 1'h1); endtask
	task open_pin; run(0, 1'h0, 1'h0, 1'h0); endtask
	task select_flip; run(1, 1'h1, 1'h1, 1'h0); run(0, 1'h0, 1'h1, 1'h1); endtask
	task qualifier_off;
		grant = 2'h0; want = 2'h3;
		repeat (4) begin
			@(negedge clk); #1 check(processorReady, 1'h0);
		end
		@(posedge clk); #2 want = 2'h0;
	endtask
	task tally_and_finish;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// ==========
	// main sequence
	initial begin
		repeat (4) @(posedge clk);
		#2 reset_n = 1'h1;
		@(posedge clk); #2;
		single_stage_a;
		two_stage_b;
		open_pin;
		select_flip;
		qualifier_off;
		tally_and_finish;
	end
	// hang guard, far beyond the few dozen cycles used
	initial begin
		#20000;
		miscompares++;
		tally_and_finish;
	end
endmodule
